// ### hw/nie_core.v
// Purpose: nmi accept, entry and return sequencing with maskable accept
// Assumes: cpu pipeline models pc advance outside; commands via wishbone
// Notes:   entry takes effect in one clock edge
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "nie_defs.vh"

// Summary of operation
// - pin nmi held until return instruction
// - watchdog held while servicing flag set
// - watchdog preempts a pin service when servicing flag clear
// - save pc and status in the same edge on entry
// - cause upper halfword gets source code
// - entry sets servicing, disable; clears pending
// - pc loads fixed handler address
// - return restores pc and status words
// - write-once watchdog mode survives software reset
// - servicing flag blocks nmi nesting
// - fifty-five individually maskable sources
// - any accept disables maskable interrupts
// - only strictly higher priority nests
// - watchdog beats pin when simultaneous
// - pin edge selectable, none at reset
// - watchdog nmi only in mode 01
// - nmi ignores disable, beats maskable
module nie_core #(
  parameter NSRC = `NIE_NUM_SRC
) (
  // clock and reset
  input  wire            clk,
  input  wire            arst_n,
  input  wire            ce,
  // wishbone slave
  input  wire            wb_cyc_i,
  input  wire            wb_stb_i,
  input  wire            wb_we_i,
  input  wire [7:0]      wb_adr_i,
  input  wire [3:0]      wb_sel_i,
  input  wire [31:0]     wb_dat_i,
  output reg  [31:0]     wb_dat_o,
  output reg             wb_ack_o,
  // request sources
  input  wire            nmi_pin,
  input  wire            wdt_overflow,
  input  wire [NSRC-1:0] mask_req,
  // cpu view
  output reg  [31:0]     pc_out,
  output reg             nmi_taken,
  output reg             mask_taken,
  output reg  [5:0]      mask_idx
);

  ////////////////////////////////////////////////////////////////////////
  // state
  reg [31:0]     pc_ff, psw_ff, fpc_ff, fpsw_ff, cause_ff;
  reg [1:0]      edge_sel_ff;
  reg [1:0]      wdmode_ff;
  reg            wdmode_lock_ff;
  reg            pin_pend_ff, wdt_pend_ff;
  reg            svc_wdt_ff, in_nmi_ff;
  reg [NSRC-1:0] mask_ff;
  reg [NSRC*3-1:0] prio_ff;
  reg [3:0]      isp_lvl_ff;

  wire       pin_hit;
  wire       arb_valid;
  wire [5:0] arb_idx;
  wire [2:0] arb_lvl;

  nie_edge_det u_edge (
    .clk      (clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .pin      (nmi_pin),
    .edge_sel (edge_sel_ff),
    .hit      (pin_hit)
  );

  nie_mask_arb #(.NSRC(NSRC)) u_arb (
    .req   (mask_req),
    .mask  (mask_ff),
    .prio  (prio_ff),
    .limit (isp_lvl_ff),
    .valid (arb_valid),
    .idx   (arb_idx),
    .lvl   (arb_lvl)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wr_en  = ce & wb_req & wb_we_i;
  wire [31:0] wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  function wr_hit;
    input [7:0] ofs;
    begin
      wr_hit = wr_en && (wb_adr_i == ofs);
    end
  endfunction

  wire cmd_return_from_interrupt_instr = wr_hit(`NIE_OFS_CMD) & wb_sel_i[0] & wb_dat_i[`NIE_CMD_RETURN_FROM_INTERRUPT_INSTR];
  wire cmd_ei   = wr_hit(`NIE_OFS_CMD) & wb_sel_i[0] & wb_dat_i[`NIE_CMD_EI];
  wire cmd_di   = wr_hit(`NIE_OFS_CMD) & wb_sel_i[0] & wb_dat_i[`NIE_CMD_DI];

  wire np = psw_ff[`NIE_PSW_NP];
  wire ep = psw_ff[`NIE_PSW_EP];
  wire id = psw_ff[`NIE_PSW_ID];

  ////////////////////////////////////////////////////////////////////////
  // acceptance
  wire wdt_qual = wdt_overflow & (wdmode_ff == `NIE_WD_NMI_MODE);
  wire wdt_any  = wdt_pend_ff | wdt_qual;
  wire pin_any  = pin_pend_ff | pin_hit;
  // pin waits for the return regardless of flag; watchdog gated by flag
  wire take_wdt = wdt_any & ~np & ~(in_nmi_ff & svc_wdt_ff);
  wire take_pin = pin_any & ~in_nmi_ff & ~np & ~take_wdt;
  wire take_nmi = take_wdt | take_pin;
  wire take_msk = arb_valid & ~take_nmi & ~id & ~np & ~cmd_return_from_interrupt_instr;
  wire do_return_from_interrupt_instr  = cmd_return_from_interrupt_instr & ~take_nmi;

  ////////////////////////////////////////////////////////////////////////
  // sequential
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_ff          <= `NIE_RST_PC;
      psw_ff         <= `NIE_RST_PSW;
      fpc_ff         <= 32'h00000000;
      fpsw_ff        <= 32'h00000000;
      cause_ff       <= 32'h00000000;
      edge_sel_ff    <= `NIE_EDGE_NONE;
      wdmode_ff      <= 2'h0;
      wdmode_lock_ff <= 1'b0;
      pin_pend_ff    <= 1'b0;
      wdt_pend_ff    <= 1'b0;
      svc_wdt_ff     <= 1'b0;
      in_nmi_ff      <= 1'b0;
      mask_ff        <= {NSRC{1'b1}};
      prio_ff        <= {(NSRC*3){1'b1}};
      isp_lvl_ff     <= 4'h8;
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h00000000;
      pc_out         <= `NIE_RST_PC;
      nmi_taken      <= 1'b0;
      mask_taken     <= 1'b0;
      mask_idx       <= 6'h00;
    end else if (ce) begin
      wb_ack_o   <= wb_req;
      nmi_taken  <= take_nmi;
      mask_taken <= take_msk;

      // pending latches: the accept clear beats a new hit
      // a pin edge that meets a watchdog accept is dropped, not held
      pin_pend_ff <= (pin_pend_ff | (pin_hit & ~take_wdt)) & ~take_pin;
      wdt_pend_ff <= (wdt_pend_ff & ~take_wdt) | (wdt_qual & ~take_wdt);

      // software register writes
      if (wr_hit(`NIE_OFS_CTRL) & wb_sel_i[0])
        edge_sel_ff <= wb_dat_i[1:0];
      if (wr_hit(`NIE_OFS_PC))
        pc_ff <= merge(pc_ff, wb_dat_i, wmask);
      if (wr_hit(`NIE_OFS_PSW))
        psw_ff <= merge(psw_ff, wb_dat_i, wmask);
      if (wr_hit(`NIE_OFS_FPC))
        fpc_ff <= merge(fpc_ff, wb_dat_i, wmask);
      if (wr_hit(`NIE_OFS_FPSW))
        fpsw_ff <= merge(fpsw_ff, wb_dat_i, wmask);
      if (wr_hit(`NIE_OFS_WDMODE) & wb_sel_i[0] & ~wdmode_lock_ff) begin
        wdmode_ff      <= wb_dat_i[1:0];
        wdmode_lock_ff <= 1'b1;
      end
      if (wr_hit(`NIE_OFS_MASK_LO))
        mask_ff[31:0] <= merge(mask_ff[31:0], wb_dat_i, wmask);
      if (wr_hit(`NIE_OFS_MASK_HI))
        mask_ff[NSRC-1:32] <= wb_dat_i[NSRC-33:0];
      if (wr_hit(`NIE_OFS_PRIO))
        prio_ff[wb_dat_i[13:8]*3 +: 3] <= wb_dat_i[2:0];
      if (cmd_ei)
        psw_ff[`NIE_PSW_ID] <= 1'b0;
      if (cmd_di)
        psw_ff[`NIE_PSW_ID] <= 1'b1;

      // entry and return override software writes
      if (take_nmi) begin
        fpc_ff   <= pc_ff;
        fpsw_ff  <= psw_ff;
        cause_ff <= {(take_wdt ? `NIE_CODE_WDT : `NIE_CODE_PIN), cause_ff[15:0]};
        psw_ff   <= (psw_ff | (32'h1 << `NIE_PSW_NP) | (32'h1 << `NIE_PSW_ID))
                    & ~(32'h1 << `NIE_PSW_EP);
        pc_ff    <= take_wdt ? `NIE_VEC_WDT : `NIE_VEC_PIN;
        pc_out   <= take_wdt ? `NIE_VEC_WDT : `NIE_VEC_PIN;
        in_nmi_ff  <= 1'b1;
        svc_wdt_ff <= take_wdt;
      end else if (take_msk) begin
        psw_ff[`NIE_PSW_ID] <= 1'b1;
        isp_lvl_ff          <= {1'b0, arb_lvl};
        mask_idx            <= arb_idx;
      end else if (do_return_from_interrupt_instr) begin
        if (!ep && np) begin
          pc_ff     <= fpc_ff;
          psw_ff    <= fpsw_ff;
          pc_out    <= fpc_ff;
          in_nmi_ff <= 1'b0;
          svc_wdt_ff <= 1'b0;
        end else if (!ep && !np) begin
          isp_lvl_ff <= 4'h8;
        end
      end else begin
        pc_out <= pc_ff;
      end

      // register reads
      if (wb_req & ~wb_we_i) begin
        case (wb_adr_i)
          `NIE_OFS_CTRL:    wb_dat_o <= {30'h0, edge_sel_ff};
          `NIE_OFS_STATUS:  wb_dat_o <= {26'h0, isp_lvl_ff[2:0], svc_wdt_ff, pin_pend_ff, wdt_pend_ff};
          `NIE_OFS_PC:      wb_dat_o <= pc_ff;
          `NIE_OFS_PSW:     wb_dat_o <= psw_ff;
          `NIE_OFS_FPC:     wb_dat_o <= fpc_ff;
          `NIE_OFS_FPSW:    wb_dat_o <= fpsw_ff;
          `NIE_OFS_CAUSE:   wb_dat_o <= cause_ff;
          `NIE_OFS_WDMODE:  wb_dat_o <= {29'h0, wdmode_lock_ff, wdmode_ff};
          `NIE_OFS_MASK_LO: wb_dat_o <= mask_ff[31:0];
          `NIE_OFS_MASK_HI: wb_dat_o <= {{(64-NSRC){1'b0}}, mask_ff[NSRC-1:32]};
          default:          wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // nie_core

// ### hw/nie_edge_det.v
// Purpose: selectable edge detector for the nmi pin
// Assumes: pin input synchronous to clk
// Notes:   sel none gives no pulse
`timescale 1ns/10ps
`include "nie_defs.vh"

module nie_edge_det (
  // clock and reset
  input  wire       clk,
  input  wire       arst_n,
  input  wire       ce,
  // pin and select
  input  wire       pin,
  input  wire [1:0] edge_sel,
  // qualified edge
  output wire       hit
);

  reg pin_ff;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_ff <= 1'b0;
    end else if (ce) begin
      pin_ff <= pin;
    end
  end

  // edge qualification
  assign hit = ce & (((edge_sel == `NIE_EDGE_RISE) & pin & ~pin_ff) |
                     ((edge_sel == `NIE_EDGE_FALL) & ~pin & pin_ff) |
                     ((edge_sel == `NIE_EDGE_BOTH) & (pin ^ pin_ff)));

endmodule // nie_edge_det

// ### hw/nie_mask_arb.v
// Purpose: maskable request arbiter
// Assumes: level requests, one priority level per source
// Notes:   lowest index wins among equal levels
`timescale 1ns/10ps
`include "nie_defs.vh"

module nie_mask_arb #(
  parameter NSRC = `NIE_NUM_SRC
) (
  // requests
  input  wire [NSRC-1:0]   req,
  input  wire [NSRC-1:0]   mask,
  input  wire [NSRC*3-1:0] prio,
  // cutoff: only levels below this value accepted
  input  wire [3:0]        limit,
  // selection
  output reg               valid,
  output reg  [5:0]        idx,
  output reg  [2:0]        lvl
);

  integer i;

  always @* begin
    valid = 1'b0;
    idx   = 6'h00;
    lvl   = 3'h7;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      // masked sources never compete
      if (req[i] && !mask[i] && ({1'b0, prio[i*3 +: 3]} < limit) &&
          (!valid || prio[i*3 +: 3] <= lvl)) begin
        valid = 1'b1;
        idx   = i[5:0];
        lvl   = prio[i*3 +: 3];
      end
    end
  end

endmodule // nie_mask_arb

// ### include/nie_defs.vh
// Purpose: constants for the non-maskable interrupt entry/return unit
// Assumes: 32-bit status word, classic wishbone register window
// Notes:   offsets are byte addresses of 32-bit words
`ifndef NIE_DEFS_VH
`define NIE_DEFS_VH

// register offsets
`define NIE_OFS_CTRL      8'h00
`define NIE_OFS_STATUS    8'h04
`define NIE_OFS_PC        8'h08
`define NIE_OFS_PSW       8'h0c
`define NIE_OFS_FPC       8'h10
`define NIE_OFS_FPSW      8'h14
`define NIE_OFS_CAUSE     8'h18
`define NIE_OFS_WDMODE    8'h1c
`define NIE_OFS_MASK_LO   8'h20
`define NIE_OFS_MASK_HI   8'h24
`define NIE_OFS_PRIO      8'h28
`define NIE_OFS_CMD       8'h2c

// status word bit positions
`define NIE_PSW_ID        5
`define NIE_PSW_EP        6
`define NIE_PSW_NP        7

// command bits
`define NIE_CMD_RETURN_FROM_INTERRUPT_INSTR      0
`define NIE_CMD_EI        1
`define NIE_CMD_DI        2

// exception codes and handler addresses
`define NIE_CODE_PIN      16'h0010
`define NIE_CODE_WDT      16'h0020
`define NIE_VEC_PIN       32'h00000010
`define NIE_VEC_WDT       32'h00000020

// edge select
`define NIE_EDGE_NONE     2'h0
`define NIE_EDGE_RISE     2'h1
`define NIE_EDGE_FALL     2'h2
`define NIE_EDGE_BOTH     2'h3

// watchdog mode value that routes overflow to the nmi
`define NIE_WD_NMI_MODE   2'h1

// reset values
`define NIE_RST_PSW       32'h00000020
`define NIE_RST_PC        32'h00000000

// maskable sources and priority levels
`define NIE_NUM_SRC       55
`define NIE_PRIO_LVLS     8

`endif

// ### sim/nie_core_asserts.sv
// Purpose: port checks for nie_core
// Assumes: bound to every nie_core instance
// Notes:   one clock domain
`timescale 1ns/10ps
`include "nie_defs.vh"
////////////////////////////////////////
module nie_core_asserts #(parameter NSRC = `NIE_NUM_SRC) (
  // clock and reset
  input logic            clk,
  input logic            arst_n,
  input logic            ce,
  // wishbone
  input logic            wb_cyc_i,
  input logic            wb_stb_i,
  input logic            wb_we_i,
  input logic [7:0]      wb_adr_i,
  input logic [3:0]      wb_sel_i,
  input logic [31:0]     wb_dat_i,
  input logic [31:0]     wb_dat_o,
  input logic            wb_ack_o,
  // sources and cpu view
  input logic            nmi_pin,
  input logic            wdt_overflow,
  input logic [NSRC-1:0] mask_req,
  input logic [31:0]     pc_out,
  input logic            nmi_taken,
  input logic            mask_taken,
  input logic [5:0]      mask_idx
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_vec; nmi_taken |-> pc_out == `NIE_VEC_PIN || pc_out == `NIE_VEC_WDT; endproperty
  a_vec: assert property (p_vec) else $error("entry pc off vector");
  property p_no_nest; nmi_taken |=> !nmi_taken; endproperty
  a_no_nest: assert property (p_no_nest) else $error("nmi nested");
  property p_nmi_first; nmi_taken |-> !mask_taken [*3]; endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("maskable during nmi entry");
  property p_di; mask_taken |=> !mask_taken; endproperty
  a_di: assert property (p_di) else $error("maskable taken while disabled");
  property p_idx; mask_taken |-> mask_idx < NSRC; endproperty
  a_idx: assert property (p_idx) else $error("source index out of range");
  property p_ack; ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no bus answer");
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
  property p_dat; !wb_ack_o |-> $stable(wb_dat_o); endproperty
  a_dat: assert property (p_dat) else $error("read data moved without ack");
endmodule // nie_core_asserts

// ### sim/nie_nmi_src.sv
// Purpose: nmi pin and watchdog overflow source
// Assumes: bench asks for levels and strobes
// Notes:   outputs registered on clk
`timescale 1ns/10ps
////////////////////////////////////////
module nie_nmi_src (
  // clock and reset
  input  logic clk,
  input  logic arst_n,
  // bench requests
  input  logic pin_lvl,
  input  logic wdt_go,
  // toward the core
  output logic nmi_pin,
  output logic wdt_overflow
);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_pin      <= 1'b0;
      wdt_overflow <= 1'b0;
    end else begin
      nmi_pin      <= pin_lvl;
      wdt_overflow <= wdt_go;
    end
  end
endmodule // nie_nmi_src

// ### sim/tb.sv
// Purpose: self-checking bench for nie_core
// Assumes: ce and byte selects held on
// Notes:   monitor compares results against queued notes
`timescale 1ns/10ps
`include "nie_defs.vh"
////////////////////////////////////////
module tb;
  localparam int NSRC = `NIE_NUM_SRC;
  logic            clk, arst_n, cyc, stb, we, ack, pin_lvl, wdt_go, nmi_pin, wdt_ov, nmi_tk, mk_tk;
  logic [7:0]      adr;
  logic [31:0]     dwr, drd, pc, rpc, radr;
  logic [NSRC-1:0] mreq;
  logic [5:0]      midx;
  logic [31:0]     q_nmi[$], q_rd[$], q_msk[$], q_mk[$];
  int              err_total, compares, a;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  nie_core #(.NSRC(NSRC)) dut (
    .clk(clk), .arst_n(arst_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack), .nmi_pin(nmi_pin), .wdt_overflow(wdt_ov),
    .mask_req(mreq), .pc_out(pc), .nmi_taken(nmi_tk), .mask_taken(mk_tk), .mask_idx(midx));
  nie_nmi_src u_src (.clk(clk), .arst_n(arst_n), .pin_lvl(pin_lvl), .wdt_go(wdt_go), .nmi_pin(nmi_pin),
    .wdt_overflow(wdt_ov));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task stall;
    err_total++;
    end_sim();
  endtask
  task wb(input logic [7:0] a_i, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a_i;
    dwr <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) stall();
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [7:0] a_i, input logic [31:0] d);
    wb(a_i, 1'b1, d);
  endtask
  task rd(input logic [7:0] a_i, input logic [31:0] m, input logic [31:0] e);
    q_msk.push_back(m);
    q_rd.push_back(e);
    wb(a_i, 1'b0, 32'h0);
  endtask
  // bounded wait until every expected entry was seen
  task drain;
    int n;
    n = 0;
    while (q_nmi.size() + q_mk.size() != 0 && n < 30) begin
      @(posedge clk);
      n++;
    end
    if (n >= 30) stall();
  endtask
  task pin(input logic v);
    @(posedge clk);
    pin_lvl <= v;
  endtask
  task fire(input logic p);
    @(posedge clk);
    pin_lvl <= p;
    wdt_go  <= 1'b1;
    @(posedge clk);
    wdt_go  <= 1'b0;
  endtask
  function automatic logic [NSRC-1:0] bit_at(input int i);
    bit_at = '0;
    bit_at[i] = 1'b1;
  endfunction
  ////////////////////////////////////////
  always @(posedge clk) begin
    if (nmi_tk === 1'b1)
      chk(pc, q_nmi.size() != 0 ? q_nmi.pop_front() : '1);
    if (mk_tk === 1'b1)
      chk({26'h0, midx}, q_mk.size() != 0 ? q_mk.pop_front() : '1);
    if (ack === 1'b1 && we === 1'b0)
      chk(drd & q_msk.pop_front(), q_rd.pop_front());
  end
  initial begin
    {arst_n, cyc, stb, we, pin_lvl, wdt_go} = 6'h0;
    adr = 8'h0;
    dwr = 32'h0;
    mreq = '0;
    a = $urandom(32'h450a);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(`NIE_OFS_PSW, '1, `NIE_RST_PSW);
    rd(`NIE_OFS_CTRL, 32'h3, `NIE_EDGE_NONE);
    rd(8'h30, '1, 32'h0);
    // maskable: accept, hold while disabled, nest higher, refuse equal
    a = $urandom % NSRC;
    wr(`NIE_OFS_PSW, 32'h0);
    wr(`NIE_OFS_MASK_LO, 32'h0);
    wr(`NIE_OFS_MASK_HI, 32'h0);
    for (int i = 0; i < 3; i++) wr(`NIE_OFS_PRIO, (((a + i) % NSRC) << 8) | (i == 0 ? 2 : 1));
    q_mk.push_back(a);
    mreq <= bit_at(a);
    drain;
    mreq <= bit_at((a + 1) % NSRC);
    repeat (8) @(posedge clk);
    q_mk.push_back((a + 1) % NSRC);
    wr(`NIE_OFS_CMD, 32'h1 << `NIE_CMD_EI);
    drain;
    mreq <= bit_at((a + 2) % NSRC);
    wr(`NIE_OFS_CMD, 32'h1 << `NIE_CMD_EI);
    repeat (8) @(posedge clk);
    mreq <= '0;
    // pin edge modes none, fall, both, then rise
    rpc = $urandom;
    wr(`NIE_OFS_PSW, `NIE_RST_PSW);
    wr(`NIE_OFS_PC, rpc);
    pin(1'b1);
    repeat (8) @(posedge clk);
    for (int i = 2; i <= 3; i++) begin
      wr(`NIE_OFS_CTRL, i);
      q_nmi.push_back(`NIE_VEC_PIN);
      pin(i == 3);
      drain;
      wr(`NIE_OFS_CMD, 32'h1);
    end
    wr(`NIE_OFS_CTRL, `NIE_EDGE_RISE);
    pin(1'b0);
    q_nmi.push_back(`NIE_VEC_PIN);
    pin(1'b1);
    drain;
    rd(`NIE_OFS_FPC, '1, rpc);
    rd(`NIE_OFS_FPSW, '1, `NIE_RST_PSW);
    rd(`NIE_OFS_CAUSE, 32'hffff0000, {`NIE_CODE_PIN, 16'h0});
    rd(`NIE_OFS_PSW, 32'he0, 32'ha0);
    pin(1'b0);
    pin(1'b1);
    repeat (8) @(posedge clk);
    q_nmi.push_back(`NIE_VEC_PIN);
    wr(`NIE_OFS_CMD, 32'h1);
    drain;
    rd(`NIE_OFS_FPC, '1, rpc);
    // watchdog held, then taken once the return clears the flag
    wr(`NIE_OFS_WDMODE, `NIE_WD_NMI_MODE);
    fire(pin_lvl);
    repeat (8) @(posedge clk);
    q_nmi.push_back(`NIE_VEC_WDT);
    wr(`NIE_OFS_CMD, 32'h1);
    drain;
    rd(`NIE_OFS_CAUSE, 32'hffff0000, {`NIE_CODE_WDT, 16'h0});
    wr(`NIE_OFS_WDMODE, 32'h2);
    rd(`NIE_OFS_WDMODE, 32'h3, `NIE_WD_NMI_MODE);
    // leave watchdog service, then clear the flag inside a pin service
    wr(`NIE_OFS_CMD, 32'h1);
    q_nmi.push_back(`NIE_VEC_PIN);
    pin(1'b0);
    pin(1'b1);
    drain;
    wr(`NIE_OFS_PSW, `NIE_RST_PSW);
    q_nmi.push_back(`NIE_VEC_WDT);
    fire(pin_lvl);
    drain;
    radr = $urandom;
    wr(`NIE_OFS_FPC, radr);
    wr(`NIE_OFS_FPSW, 32'h80);
    wr(`NIE_OFS_CMD, 32'h1);
    rd(`NIE_OFS_PC, '1, radr);
    wr(`NIE_OFS_PSW, `NIE_RST_PSW);
    pin(1'b0);
    q_nmi.push_back(`NIE_VEC_WDT);
    fire(1'b1);
    drain;
    repeat (8) @(posedge clk);
    chk(q_rd.size() + q_nmi.size() + q_mk.size(), 0);
    end_sim();
  end
endmodule // tb
bind nie_core nie_core_asserts #(.NSRC(NSRC)) u_chk (
  .clk(clk), .arst_n(arst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .nmi_pin(nmi_pin), .wdt_overflow(wdt_overflow), .mask_req(mask_req), .pc_out(pc_out),
  .nmi_taken(nmi_taken), .mask_taken(mask_taken), .mask_idx(mask_idx));
